//--- verilog/lrc_pkg.sv
/*
 * Constants for the ladder reference control block: register map, field
 * positions, reset values and source select codes.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
package lrc_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] ADDR_MAIN = 8'h00;
	localparam logic [7:0] ADDR_LEVEL = 8'h04;
	localparam int ADDR_W = 8;

	// ==========================================================
	// Field positions in the main control register
	localparam int BIT_ENABLE = 7;
	localparam int BIT_LOW_POWER = 6;
	localparam int BIT_PIN_OE = 5;
	localparam int BIT_PSS_HI = 3;
	localparam int BIT_PSS_LO = 2;
	localparam int BIT_NSS = 0;
	localparam logic [7:0] MAIN_WMASK = 8'hED;
	localparam logic [7:0] LEVEL_WMASK = 8'h1F;

	// ==========================================================
	// Widths and reset values
	localparam int LEVEL_W = 5;
	localparam int LEVEL_STEPS = 32;
	localparam logic [7:0] MAIN_RESET = 8'h00;
	localparam logic [7:0] LEVEL_RESET = 8'h00;

	// ==========================================================
	// Positive source select codes
	localparam logic [1:0] PSS_SUPPLY = 2'h0;
	localparam logic [1:0] PSS_EXT_REF = 2'h1;
	localparam logic [1:0] PSS_FIXED_BUF = 2'h2;
	localparam logic [1:0] PSS_RESERVED = 2'h3;

	// ==========================================================
	// AHB encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [1:0] {
		LRC_SRC_SUPPLY,
		LRC_SRC_EXT,
		LRC_SRC_FIXED,
		LRC_SRC_NONE
	} lrc_src_e;

endpackage : lrc_pkg

//--- verilog/lrc_reg_if.sv
/*
 * Carrier between the bus slave and the control register core.
 * Assumes both ends run on the same clock.
 */
interface lrc_reg_if;
	logic wr_main;
	logic wr_level;
	logic [7:0] wdata;
	logic [7:0] main_rd;
	logic [7:0] level_rd;

	modport slave (output wr_main, output wr_level, output wdata,
		input main_rd, input level_rd);
	modport core (input wr_main, input wr_level, input wdata,
		output main_rd, output level_rd);
endinterface : lrc_reg_if

//--- verilog/lrc_regs.sv
/*
 * Control register core: holds the main control and level code registers.
 * Assumes write strobes arrive one cycle wide on the module clock.
 */
module lrc_regs (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	input wire logic clk_en,
	// Register access
	lrc_reg_if.core rif,
	// Stored values
	output logic [7:0] main_q,
	output logic [lrc_pkg::LEVEL_W-1:0] level_q
);

	// ==========================================================
	// Storage
	// Sleep and wake do not touch these flops; only nrst clears them.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			main_q <= lrc_pkg::MAIN_RESET;
			level_q <= '0;
		end else if (clk_en) begin
			if (rif.wr_main) begin
				main_q <= rif.wdata & lrc_pkg::MAIN_WMASK;
			end
			if (rif.wr_level) begin
				level_q <= rif.wdata[lrc_pkg::LEVEL_W-1:0];
			end
		end
	end

	assign rif.main_rd = main_q;
	assign rif.level_rd = {3'h0, level_q};

endmodule : lrc_regs

//--- verilog/lrc_top.sv
/*
 * Ladder reference control: AHB-Lite slave with two 8-bit control
 * registers driving static controls of a 32-step resistor ladder.
 * Assumes the analog ladder and pad sit outside and take these controls.
 */
module lrc_top (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	input wire logic clk_en,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Analog ladder controls
	output logic converter_enable,
	output logic low_power_side_select,
	output logic disconnect_negative,
	output logic disconnect_positive,
	output logic [1:0] positive_source_select,
	output lrc_pkg::lrc_src_e positive_source,
	output logic negative_source_select,
	output logic [lrc_pkg::LEVEL_W-1:0] level_code,
	output logic pin_output_enable,
	// Reference output pin digital pad
	input wire logic pad_in,
	input wire logic port_out,
	input wire logic port_oe,
	output logic pad_out,
	output logic pad_oe,
	output logic pin_read_value
);

	// ==========================================================
	// Bus address phase capture
	lrc_reg_if rif ();
	logic wr_pend_q;
	logic rd_pend_q;
	logic [lrc_pkg::ADDR_W-1:0] addr_q;
	logic [31:0] hrdata_q;
	logic [7:0] main_q;
	logic [lrc_pkg::LEVEL_W-1:0] level_q;
	wire addr_take = hsel && hready && htrans == lrc_pkg::HTRANS_NONSEQ;
	wire sel_main = addr_q == lrc_pkg::ADDR_MAIN;
	wire sel_level = addr_q == lrc_pkg::ADDR_LEVEL;
	wire [lrc_pkg::ADDR_W-1:0] haddr_lo = haddr[lrc_pkg::ADDR_W-1:0];
	wire hi_zero = haddr[31:lrc_pkg::ADDR_W] == '0;
	wire [7:0] rd_mux = (haddr_lo == lrc_pkg::ADDR_MAIN && hi_zero) ?
		rif.main_rd : ((haddr_lo == lrc_pkg::ADDR_LEVEL && hi_zero) ?
		rif.level_rd : 8'h00);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= '0;
			hrdata_q <= '0;
		end else if (clk_en) begin
			wr_pend_q <= addr_take && hwrite && hi_zero;
			rd_pend_q <= addr_take && !hwrite;
			addr_q <= haddr_lo;
			if (addr_take && !hwrite) begin
				hrdata_q <= {24'h0, rd_mux};
			end
		end
	end

	// ==========================================================
	// Write decode; unmapped addresses are accepted and dropped.
	assign rif.wr_main = clk_en && wr_pend_q && sel_main;
	assign rif.wr_level = clk_en && wr_pend_q && sel_level;
	assign rif.wdata = hwdata[7:0];
	assign hrdata = hrdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	lrc_regs u_regs (
		.mclk(mclk),
		.nrst(nrst),
		.clk_en(clk_en),
		.rif(rif),
		.main_q(main_q),
		.level_q(level_q)
	);

	// ==========================================================
	// Static ladder controls
	assign converter_enable = main_q[lrc_pkg::BIT_ENABLE];
	assign low_power_side_select = main_q[lrc_pkg::BIT_LOW_POWER];
	assign disconnect_negative = low_power_side_select;
	assign disconnect_positive = !low_power_side_select;
	assign positive_source_select =
		main_q[lrc_pkg::BIT_PSS_HI:lrc_pkg::BIT_PSS_LO];
	// Reserved code selects nothing so the ladder top is never shorted.
	assign positive_source = (positive_source_select ==
		lrc_pkg::PSS_SUPPLY) ? lrc_pkg::LRC_SRC_SUPPLY :
		(positive_source_select == lrc_pkg::PSS_EXT_REF) ?
		lrc_pkg::LRC_SRC_EXT :
		(positive_source_select == lrc_pkg::PSS_FIXED_BUF) ?
		lrc_pkg::LRC_SRC_FIXED : lrc_pkg::LRC_SRC_NONE;
	assign negative_source_select = main_q[lrc_pkg::BIT_NSS];
	assign level_code = level_q;
	assign pin_output_enable = main_q[lrc_pkg::BIT_PIN_OE];

	// ==========================================================
	// Pad override
	logic pad_s1_q;
	logic pad_s2_q;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pad_s1_q <= 1'b0;
			pad_s2_q <= 1'b0;
		end else if (clk_en) begin
			pad_s1_q <= pad_in;
			pad_s2_q <= pad_s1_q;
		end
	end
	assign pad_oe = port_oe && !pin_output_enable;
	assign pad_out = port_out && !pin_output_enable;
	assign pin_read_value = pad_s2_q && !pin_output_enable;

	// ==========================================================
	// Checks
	sequence main_write_s;
		clk_en && wr_pend_q && sel_main;
	endsequence

	// Two conditions of a write that clears the enable: strobe and data low in the same cycle.
	sequence main_clear_s;
		main_write_s ##0 !hwdata[lrc_pkg::BIT_ENABLE];
	endsequence

	// The pad request that the reference must override.
	sequence pin_taken_s;
		pin_output_enable && port_out && port_oe;
	endsequence

	reset_clear_a: assert property (@(posedge mclk)
		$rose(nrst) |-> main_q == 8'h00 && level_q == '0)
		else $error("controls not cleared by reset");
	unimpl_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
		(main_q & ~lrc_pkg::MAIN_WMASK) == 8'h00)
		else $error("unimplemented main bits set");
	enable_write_a: assert property (@(posedge mclk) disable iff (!nrst)
		main_write_s ##0 hwdata[lrc_pkg::BIT_ENABLE] |=>
		converter_enable)
		else $error("enable bit not taken from write");
	main_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
		!(clk_en && wr_pend_q && sel_main) |=> $stable(main_q))
		else $error("main register changed without write");
	level_write_a: assert property (@(posedge mclk) disable iff (!nrst)
		rif.wr_level |=>
		level_code == $past(hwdata[lrc_pkg::LEVEL_W-1:0]))
		else $error("level code not right justified");
	pin_read_a: assert property (@(posedge mclk) disable iff (!nrst)
		pin_output_enable |-> !pin_read_value && !pad_oe)
		else $error("pad active while reference on pin");
	lps_side_a: assert property (@(posedge mclk) disable iff (!nrst)
		disconnect_negative != disconnect_positive &&
		disconnect_negative == main_q[lrc_pkg::BIT_LOW_POWER])
		else $error("wrong side disconnected");
	nss_follow_a: assert property (@(posedge mclk) disable iff (!nrst)
		main_write_s |=>
		negative_source_select == $past(hwdata[lrc_pkg::BIT_NSS]))
		else $error("negative select not written");
	pss_map_a: assert property (@(posedge mclk) disable iff (!nrst)
		positive_source_select == lrc_pkg::PSS_FIXED_BUF |->
		positive_source == lrc_pkg::LRC_SRC_FIXED)
		else $error("positive select decode wrong");
	level_steady_a: assert property (@(posedge mclk) disable iff (!nrst)
		!rif.wr_level |=> $stable(level_code))
		else $error("level code changed without write");
	enable_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
		main_clear_s |=> !converter_enable)
		else $error("enable bit not cleared by write");
	pad_drive_a: assert property (@(posedge mclk) disable iff (!nrst)
		pin_taken_s |-> !pad_out)
		else $error("pad driven while reference on pin");
	read_upper_a: assert property (@(posedge mclk) disable iff (!nrst)
		rd_pend_q |-> hrdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	pss_ext_a: assert property (@(posedge mclk) disable iff (!nrst)
		positive_source_select == lrc_pkg::PSS_EXT_REF |->
		positive_source == lrc_pkg::LRC_SRC_EXT)
		else $error("external select decode wrong");
	pss_none_a: assert property (@(posedge mclk) disable iff (!nrst)
		positive_source_select == lrc_pkg::PSS_RESERVED |->
		positive_source == lrc_pkg::LRC_SRC_NONE)
		else $error("reserved select not isolated");

endmodule : lrc_top

//--- tb/lrc_tb_top.sv
/*
 * Self-checking bench for the ladder reference control block.
 * Assumes one AHB-Lite master, the bench, with hready fed from hreadyout.
 */
module lrc_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Stimulus and observed signals
	logic mclk = 0, nrst = 0, clk_en = 1, hsel = 0, hwrite = 0;
	logic pad_in = 0, port_out = 0, port_oe = 0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic [1:0] htrans = '0, pss;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, ce, lps, dn, dp, nss, poe, pout, poen, prv;
	lrc_pkg::lrc_src_e ps;
	logic [4:0] lvl;
	int mismatches = 0, n_compared = 0, cycles = 0;
	always #2 mclk = ~mclk;
	lrc_top DUT (.mclk(mclk), .nrst(nrst), .clk_en(clk_en), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .converter_enable(ce),
		.low_power_side_select(lps), .disconnect_negative(dn),
		.disconnect_positive(dp), .positive_source_select(pss),
		.positive_source(ps), .negative_source_select(nss),
		.level_code(lvl), .pin_output_enable(poe), .pad_in(pad_in),
		.port_out(port_out), .port_oe(port_oe), .pad_out(pout),
		.pad_oe(poen), .pin_read_value(prv));
	// ==========================================================
	// Shared tasks
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic bus(logic [31:0] a, logic wr, logic [31:0] d,
		output logic [31:0] rd);
		@(posedge mclk);
		hsel <= 1'b1; haddr <= a; hwrite <= wr;
		htrans <= lrc_pkg::HTRANS_NONSEQ; hsize <= lrc_pkg::HSIZE_WORD;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0; hsel <= 1'b0; hwdata <= wr ? d : 32'h0;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic wr(logic [31:0] a, logic [31:0] d);
		logic [31:0] x;
		bus(a, 1'b1, d, x);
		repeat (2) @(posedge mclk);
		#1;
	endtask : wr
	task automatic rd(string nm, logic [31:0] a, logic [31:0] exp);
		logic [31:0] x;
		bus(a, 1'b0, 32'h0, x);
		check(nm, x, exp);
	endtask : rd
	// ==========================================================
	// Scenarios
	task automatic t_main;
		wr(32'(lrc_pkg::ADDR_MAIN), 32'hFF);
		check("enable", ce, 1);
		check("disc_neg", {dn, dp, lps}, 3'b101);
		check("pin_oe", poe, 1);
		check("nss", nss, 1);
		rd("main", 32'(lrc_pkg::ADDR_MAIN), 32'hED);
		wr(32'(lrc_pkg::ADDR_MAIN), 32'h00);
		check("disc_pos", {dn, dp, lps, ce, nss}, 5'b01000);
	endtask : t_main
	task automatic t_pss;
		lrc_pkg::lrc_src_e tbl[4] = '{lrc_pkg::LRC_SRC_SUPPLY,
			lrc_pkg::LRC_SRC_EXT, lrc_pkg::LRC_SRC_FIXED, lrc_pkg::LRC_SRC_NONE};
		for (int i = 0; i < 4; i++) begin
			wr(32'(lrc_pkg::ADDR_MAIN), 32'(i) << 2);
			check("pss", pss, 32'(i));
			check("psrc", ps, tbl[i]);
		end
	endtask : t_pss
	task automatic t_level;
		wr(32'(lrc_pkg::ADDR_LEVEL), 32'hFF);
		rd("level", 32'(lrc_pkg::ADDR_LEVEL), 32'h1F);
		check("code", lvl, 5'h1F);
		wr(32'(lrc_pkg::ADDR_MAIN), 32'h48);
		check("clamp_hi", {ce, dn, pss}, 4'b0110);
		wr(32'(lrc_pkg::ADDR_LEVEL), 32'h00);
		wr(32'(lrc_pkg::ADDR_MAIN), 32'h01);
		check("clamp_lo", {ce, dp, nss, lvl}, 8'h60);
	endtask : t_level
	task automatic t_pin(logic oe);
		@(posedge mclk);
		port_out <= 1'b1; port_oe <= 1'b1; pad_in <= 1'b1;
		wr(32'(lrc_pkg::ADDR_MAIN), {26'h0, oe, 5'h0});
		repeat (3) @(posedge mclk);
		#1;
		check("pad_oe", poen, !oe);
		check("pad_out", pout, !oe);
		check("pin_read", prv, !oe);
	endtask : t_pin
	task automatic t_hold;
		wr(32'h08, 32'hFF);
		rd("unmapped", 32'h08, 32'h0);
		wr(32'(lrc_pkg::ADDR_MAIN), 32'hA5);
		wr(32'(lrc_pkg::ADDR_LEVEL), 32'h0A);
		@(posedge mclk);
		clk_en <= 1'b0;
		wr(32'(lrc_pkg::ADDR_MAIN), 32'h00);
		@(posedge mclk);
		clk_en <= 1'b1;
		check("held", ce, 1);
		rd("kept", 32'(lrc_pkg::ADDR_MAIN), 32'hA5);
		wr(32'(lrc_pkg::ADDR_MAIN), 32'h25);
		check("sleep_off", {ce, poe}, 2'b01);
		@(posedge mclk);
		nrst <= 1'b0;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		#1;
		check("rst_ctl", {ce, poe, lvl}, 7'h0);
		rd("rst_lvl", 32'(lrc_pkg::ADDR_LEVEL), 32'h0);
	endtask : t_hold
	// ==========================================================
	// Closing report and sequence
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize
	// The ceiling is about 25 times the length of the full sequence.
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			summarize();
		end
	end
	initial begin
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		rd("rst_main", 32'(lrc_pkg::ADDR_MAIN), 32'h0);
		check("rst_out", {ce, lps, poe, pss, nss, lvl}, 11'h0);
		t_main();
		t_pss();
		t_level();
		t_pin(1'b1);
		t_pin(1'b0);
		t_hold();
		summarize();
	end
endmodule : lrc_tb_top
